// ### core/mfp_commutate.sv
`timescale 1ns/1ns
module mfp_commutate
(
   input wire logic [2:0] sensor,
   input wire logic sel60,
   input wire logic dir,
   output logic valid,
   output logic [2:0] top_on,
   output logic [2:0] bot_on
);

   // =====================================================================
   // six step decoder
   // =====================================================================
   // step index 0..5 from the sensor code, 7 for an invalid code
   logic [2:0] step;
   logic [2:0] step_dir;

   always_comb
   begin
      step = 3'h7;
      if (sel60)
      begin
         case (sensor)
            3'h4: step = 3'h0;
            3'h6: step = 3'h1;
            3'h7: step = 3'h2;
            3'h3: step = 3'h3;
            3'h1: step = 3'h4;
            3'h0: step = 3'h5;
            default: step = 3'h7;
         endcase
      end
      else
      begin
         case (sensor)
            3'h5: step = 3'h0;
            3'h4: step = 3'h1;
            3'h6: step = 3'h2;
            3'h2: step = 3'h3;
            3'h3: step = 3'h4;
            3'h1: step = 3'h5;
            default: step = 3'h7;
         endcase
      end
   end

   assign valid = (step != 3'h7);
   // reverse runs the same table three steps on
   assign step_dir = (!dir || !valid) ? step : (step >= 3'h3 ? step - 3'h3 : step + 3'h3);

   // one top and one bottom, always of different legs
   always_comb
   begin
      top_on = 3'h0;
      bot_on = 3'h0;
      case (step_dir)
         3'h0: begin top_on = 3'h1; bot_on = 3'h4; end
         3'h1: begin top_on = 3'h2; bot_on = 3'h4; end
         3'h2: begin top_on = 3'h2; bot_on = 3'h1; end
         3'h3: begin top_on = 3'h4; bot_on = 3'h1; end
         3'h4: begin top_on = 3'h4; bot_on = 3'h2; end
         3'h5: begin top_on = 3'h1; bot_on = 3'h2; end
         default: begin top_on = 3'h0; bot_on = 3'h0; end
      endcase
   end

endmodule : mfp_commutate

// ### core/mfp_fault_ctrl.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Notes on behaviour
// - fault pin low on bad sensor code, enable low, overcurrent, undervoltage, thermal
// - three undervoltage monitors, logic, bottom supply and reference, each own flag
// - any undervoltage: fault, all top drives off, all bottom drives low
// - thermal shutdown acts on fault pin and drives exactly like enable driven low, but sets its own flag
// - six step drive: one top, one bottom, different legs
// - overcurrent ends bottom conduction for the rest of the oscillator period, except under brake
// - invalid code: all off with brake low, all bottoms on with brake
module mfp_fault_ctrl
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [2:0] SENSOR,
   input wire logic ENABLE,
   input wire logic BRAKE,
   input wire logic OVERCUR,
   input wire logic UV_LOGIC,
   input wire logic UV_BOTTOM,
   input wire logic UV_REF,
   input wire logic THERMAL,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   output logic FAULT_N_O,
   output logic FAULT_N_OE,
   output logic [2:0] TOP_N_O,
   output logic [2:0] TOP_N_OE,
   output logic [2:0] BOTTOM
);

   // =====================================================================
   // input synchronisers
   // =====================================================================
   mfp_pkg::mfp_in_t raw;
   mfp_pkg::mfp_in_t meta_r;
   mfp_pkg::mfp_in_t in_r;

   assign raw = '{sensor: SENSOR, enable: ENABLE, brake: BRAKE, overcur: OVERCUR,
                  uv_logic: UV_LOGIC, uv_bottom: UV_BOTTOM, uv_ref: UV_REF,
                  thermal: THERMAL};

   // pins are asynchronous; two stages before any logic looks at them
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         meta_r <= '0;
         in_r <= '0;
      end
      else
      begin
         meta_r <= raw;
         in_r <= meta_r;
      end
   end

   // =====================================================================
   // registers
   // =====================================================================
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] mask_r;
   logic [7:0] ctrl_r;
   logic [7:0] duty_r;
   logic [7:0] live;
   logic [7:0] events;
   logic [7:0] rdata_nxt;
   logic [7:0] rdata_r;

   // =====================================================================
   // oscillator ramp and dual latch
   // =====================================================================
   logic [mfp_pkg::OSC_W-1:0] ramp_r;
   logic osc_wrap;
   logic pwm_on_r;
   logic ilim_r;
   logic pwm_gate;

   assign osc_wrap = (ramp_r == mfp_pkg::OSC_LAST);

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         ramp_r <= '0;
      else if (osc_wrap)
         ramp_r <= '0;
      else
         ramp_r <= ramp_r + 8'h01;
   end

   // at the start of each ramp the pulse latch sets if duty_r is nonzero and the limit latch clears; until then the first can only clear, the second only set
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         pwm_on_r <= 1'b0;
         ilim_r <= 1'b0;
      end
      else if (osc_wrap)
      begin
         pwm_on_r <= (duty_r != 8'h00); // zero duty must not leak a one-cycle pulse
         ilim_r <= 1'b0;
      end
      else
      begin
         // clear one step early so the pulse spans exactly duty_r ramp counts
         if ((ramp_r + 8'h01) >= duty_r)
            pwm_on_r <= 1'b0;
         if (in_r.overcur)
            ilim_r <= 1'b1;
      end
   end

   // overcurrent cuts in the very cycle it is seen, then holds off till wrap
   assign pwm_gate = pwm_on_r & ~ilim_r & ~in_r.overcur;

   // =====================================================================
   // commutation and fault combining
   // =====================================================================
   logic valid;
   logic [2:0] step_top;
   logic [2:0] step_bot;
   logic uv_any;
   logic en_eff;
   logic fault_nxt;
   logic fault_r;
   mfp_pkg::mfp_drive_t drv_nxt;
   mfp_pkg::mfp_drive_t drv_r;

   mfp_commutate u_commutate
   (
      .sensor(in_r.sensor),
      .sel60(ctrl_r[mfp_pkg::CTRL_SEL60]),
      .dir(ctrl_r[mfp_pkg::CTRL_DIR]),
      .valid(valid),
      .top_on(step_top),
      .bot_on(step_bot)
   );

   assign uv_any = in_r.uv_logic | in_r.uv_bottom | in_r.uv_ref;
   assign en_eff = in_r.enable & ~in_r.thermal;
   assign fault_nxt = ~valid | ~en_eff | in_r.overcur | uv_any;

   // priority: undervoltage, brake, invalid code or disable, normal stepping
   always_comb
   begin
      drv_nxt = '0;
      if (uv_any)
         drv_nxt = '0;
      else if (in_r.brake)
         drv_nxt.bot_on = 3'h7;
      else if (!valid || !en_eff)
         drv_nxt = '0;
      else
      begin
         drv_nxt.top_on = step_top;
         drv_nxt.bot_on = step_bot & {3{pwm_gate}};
      end
   end

   // fault and drives share one register stage so they move together
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         fault_r <= 1'b1;
         drv_r <= '0;
      end
      else
      begin
         fault_r <= fault_nxt;
         drv_r <= drv_nxt;
      end
   end

   // open collector pins: enable the pull-down while active
   assign FAULT_N_O = 1'b0;
   assign FAULT_N_OE = fault_r;
   assign TOP_N_O = 3'h0;
   assign TOP_N_OE = drv_r.top_on;
   assign BOTTOM = drv_r.bot_on;

   // =====================================================================
   // events, status and interrupt
   // =====================================================================
   assign live = {fault_nxt, in_r.thermal, in_r.uv_ref, in_r.uv_bottom, in_r.uv_logic,
                  in_r.overcur, ~in_r.enable, ~valid};
   assign events = live;

   // set beats the write-one clear in the same cycle
   assign status_nxt = (status_r & ~((WR && ADDR == mfp_pkg::ADR_STATUS) ? WDATA : 8'h00))
                       | events;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         status_r <= '0;
         mask_r <= mfp_pkg::MASK_RST;
         ctrl_r <= mfp_pkg::CTRL_RST;
         duty_r <= mfp_pkg::DUTY_RST;
      end
      else
      begin
         status_r <= status_nxt;
         if (WR && ADDR == mfp_pkg::ADR_MASK)
            mask_r <= WDATA;
         if (WR && ADDR == mfp_pkg::ADR_CTRL)
            ctrl_r <= {6'h00, WDATA[1:0]};
         if (WR && ADDR == mfp_pkg::ADR_DUTY)
            duty_r <= (WDATA > mfp_pkg::DUTY_FULL) ? mfp_pkg::DUTY_FULL : WDATA;
      end
   end

   assign IRQ = |(status_r & mask_r);

   // =====================================================================
   // read port
   // =====================================================================
   always_comb
   begin
      case (ADDR)
         mfp_pkg::ADR_STATUS: rdata_nxt = status_r;
         mfp_pkg::ADR_MASK: rdata_nxt = mask_r;
         mfp_pkg::ADR_CTRL: rdata_nxt = ctrl_r;
         mfp_pkg::ADR_LIVE: rdata_nxt = live;
         mfp_pkg::ADR_DUTY: rdata_nxt = duty_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         rdata_r <= 8'h00;
      else if (RD)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= 8'h00;
   end

   assign RDATA = rdata_r;

endmodule : mfp_fault_ctrl

// ### shared/mfp_pkg.sv
package mfp_pkg;

   // =====================================================================
   // thresholds and timing
   // =====================================================================
   localparam int CLK_HZ = 10000000;
   localparam int OSC_PERIOD_NS = 20000;
   localparam int OSC_CYCLES = (OSC_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int OSC_W = 8;
   localparam int ISENSE_MV = 100;
   localparam int UV_LOGIC_MV = 9100;
   localparam int UV_BOTTOM_MV = 9100;
   localparam int UV_REF_MV = 4500;
   localparam int TSD_DEGC = 170;
   localparam logic [OSC_W-1:0] OSC_LAST = 8'(OSC_CYCLES - 1);
   localparam logic [OSC_W-1:0] DUTY_FULL = 8'(OSC_CYCLES);

   // =====================================================================
   // register map
   // =====================================================================
   localparam logic [3:0] ADR_STATUS = 4'h0;
   localparam logic [3:0] ADR_MASK = 4'h1;
   localparam logic [3:0] ADR_CTRL = 4'h2;
   localparam logic [3:0] ADR_LIVE = 4'h3;
   localparam logic [3:0] ADR_DUTY = 4'h4;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;

   // sticky event bit positions
   localparam int EV_SENSOR = 0;
   localparam int EV_ENABLE = 1;
   localparam int EV_OVERCUR = 2;
   localparam int EV_UV_LOGIC = 3;
   localparam int EV_UV_BOTTOM = 4;
   localparam int EV_UV_REF = 5;
   localparam int EV_THERMAL = 6;
   localparam int EV_ANY = 7;
   localparam int NUM_EV = 8;

   // control bit positions
   localparam int CTRL_SEL60 = 0;
   localparam int CTRL_DIR = 1;

   // sampled comparator and pin inputs
   typedef struct packed {
      logic [2:0] sensor;
      logic enable;
      logic brake;
      logic overcur;
      logic uv_logic;
      logic uv_bottom;
      logic uv_ref;
      logic thermal;
   } mfp_in_t;

   // switch drive commands, active high = conducting
   typedef struct packed {
      logic [2:0] top_on;
      logic [2:0] bot_on;
   } mfp_drive_t;

endpackage : mfp_pkg

// ### test/mfp_bridge_model.sv
`timescale 1ns/1ns
// =====
// far side: fault pin pull-up and delayed enable latch
module mfp_bridge_model
#(
   parameter int DLY = 40
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fault_oe,
   input wire logic clr,
   output logic fault_pin,
   output logic latched
);
   int cnt = 0;
   // open collector line with a pull-up
   assign fault_pin = ~fault_oe;
   // only a long fault trips; enable low then holds fault by itself
   always @(posedge clk)
   begin
      if (!rst_n || clr)
      begin
         cnt <= 0;
         latched <= 1'b0;
      end
      else if (fault_pin)
         cnt <= 0;
      else if (cnt < DLY)
         cnt <= cnt + 1;
      else
         latched <= 1'b1;
   end
endmodule : mfp_bridge_model

// ### test/mfp_fault_props.sv
`timescale 1ns/1ns
// =====
// port checker for the fault block
module mfp_fault_props
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [2:0] SENSOR,
   input wire logic ENABLE,
   input wire logic BRAKE,
   input wire logic OVERCUR,
   input wire logic UV_LOGIC,
   input wire logic UV_BOTTOM,
   input wire logic UV_REF,
   input wire logic THERMAL,
   input wire logic FAULT_N_OE,
   input wire logic [2:0] TOP_N_OE,
   input wire logic [2:0] BOTTOM
);
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   // pins pass two sync flops, so causes are held five cycles
   wire uv = UV_LOGIC | UV_BOTTOM | UV_REF;
   wire good = SENSOR inside {3'h1, 3'h3, 3'h4, 3'h6};
   wire off = TOP_N_OE == 3'h0 && BOTTOM == 3'h0;
   sequence s_uv;
      uv [*5];
   endsequence
   sequence s_calm;
      (good && ENABLE && !OVERCUR && !uv && !THERMAL && !BRAKE) [*5];
   endsequence
   property p_uv;
      s_uv |-> FAULT_N_OE && off;
   endproperty
   a_uv: assert property (p_uv) else $error("uv drive not safe");
   property p_src;
      (!ENABLE || OVERCUR || THERMAL) [*5] |-> FAULT_N_OE;
   endproperty
   a_src: assert property (p_src) else $error("fault not shown");
   property p_calm;
      s_calm |-> !FAULT_N_OE;
   endproperty
   a_calm: assert property (p_calm) else $error("fault without cause");
   property p_therm;
      (THERMAL && !BRAKE) [*5] |-> off;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal drive on");
   property p_pair;
      TOP_N_OE != 3'h0 |-> $onehot(TOP_N_OE) && $onehot0(BOTTOM) && !(|(TOP_N_OE & BOTTOM));
   endproperty
   a_pair: assert property (p_pair) else $error("bad switch pair");
   property p_brake;
      (BRAKE && !uv) [*5] |-> TOP_N_OE == 3'h0 && BOTTOM == 3'h7;
   endproperty
   a_brake: assert property (p_brake) else $error("brake drive wrong");
   property p_oc;
      $rose(OVERCUR) && !BRAKE |-> ##[2:4] BOTTOM == 3'h0;
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent not cut");
   property p_rst;
      disable iff (1'b0) !RST_N |=> FAULT_N_OE && off;
   endproperty
   a_rst: assert property (p_rst) else $error("reset drive wrong");
endmodule : mfp_fault_props

bind mfp_fault_ctrl mfp_fault_props u_props (.*);

// ### test/motor_fault_protection_logic_tb_top.sv
`timescale 1ns/1ns
// =====
// bench: register tasks and directed tests
module motor_fault_protection_logic_tb_top;
   logic REF_CLK, RST_N, BRAKE, WR, RD, clr, latched, fpin, IRQ, FAULT_N_O, FAULT_N_OE;
   logic [2:0] SENSOR, TOP_N_O, TOP_N_OE, BOTTOM, sens_q;
   logic [3:0] ADDR;
   logic [7:0] WDATA, RDATA, rv;
   logic [5:0] fsrc;
   int n_errors, n_checks, n, tach, q;
   logic [2:0] cd [2][6] = '{'{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1},
      '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0}};
   logic [2:0] tp [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
   logic [2:0] bt [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
   // one vector of fault sources; the far latch can pull enable low
   wire ENABLE = ~fsrc[0] & ~latched;
   wire OVERCUR = fsrc[1];
   wire UV_LOGIC = fsrc[2];
   wire UV_BOTTOM = fsrc[3];
   wire UV_REF = fsrc[4];
   wire THERMAL = fsrc[5];
   mfp_fault_ctrl dut (.*);
   mfp_bridge_model #(.DLY(40)) far (.clk(REF_CLK), .rst_n(RST_N), .fault_oe(FAULT_N_OE),
      .clr(clr), .fault_pin(fpin), .latched(latched));
   // far tachometer: counts positive-going sensor edges
   always @(posedge REF_CLK)
   begin
      sens_q <= SENSOR;
      tach <= tach + $countones(SENSOR & ~sens_q);
   end
   // =====
   // tasks; each ends 1 ns after an edge so outputs are settled
   task automatic tick(int k);
      repeat (k) @(posedge REF_CLK);
      #1;
   endtask : tick
   task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   // far speed decoder: tenth steps up to nine, full on above
   function automatic logic [7:0] duty_of(logic [3:0] code);
      if (code > 4'h9)
         return mfp_pkg::DUTY_FULL;
      return 8'(code * (mfp_pkg::OSC_CYCLES / 10));
   endfunction : duty_of
   task automatic wr(logic [3:0] a, logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      tick(1);
      WR <= 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(logic [3:0] a, logic [7:0] e);
      ADDR <= a;
      RD <= 1'b1;
      tick(1);
      RD <= 1'b0;
      chk("rdata", RDATA, e);
      tick(1);
   endtask : rd
   task automatic wb(logic v);
      int k = 0;
      while ((|BOTTOM) !== v && k < 500)
      begin
         tick(1);
         k++;
      end
      chk("wait", 8'(k < 500), 8'h01);
   endtask : wb
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   // 10 MHz clock and a hang guard
   initial
   begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end
   initial
   begin
      #500000;
      n_errors++;
      summarize();
   end
   // main sequence
   initial
   begin
      RST_N = 1'b0;
      {BRAKE, WR, RD, clr, fsrc, ADDR, WDATA} = '0;
      SENSOR = 3'h5;
      tick(8);
      chk("rst", 8'({fpin, TOP_N_OE, BOTTOM, IRQ}), 8'h00);
      chk("pins", 8'({FAULT_N_O, TOP_N_O}), 8'h00);
      RST_N <= 1'b1;
      tick(1);
      rd(mfp_pkg::ADR_MASK, mfp_pkg::MASK_RST);
      rd(mfp_pkg::ADR_CTRL, mfp_pkg::CTRL_RST);
      rd(mfp_pkg::ADR_DUTY, mfp_pkg::DUTY_RST);
      rd(4'hF, 8'h00);
      wr(mfp_pkg::ADR_DUTY, 8'hFF);
      rd(mfp_pkg::ADR_DUTY, 8'hC8);
      // the pulse latch first sets at the end of the opening ramp
      wb(1'b1);
      n = tach;
      // six steps in both phasings, forward then reverse, at full duty
      for (int m = 0; m < 4; m++)
      begin
         wr(mfp_pkg::ADR_CTRL, 8'(m));
         for (int s = 0; s < 6; s++)
         begin
            SENSOR <= cd[m % 2][s];
            q = (s + 3 * (m / 2)) % 6;
            tick(5);
            chk("drive", 8'({TOP_N_OE, BOTTOM}), 8'({tp[q], bt[q]}));
            chk("fpin", 8'(fpin), 8'h01);
         end
      end
      chk("tach", 8'(tach - n), 8'h0C);
      wr(mfp_pkg::ADR_CTRL, 8'h01);
      wr(mfp_pkg::ADR_STATUS, 8'hFF);
      // each fault source alone; short so the far latch stays open
      for (int i = 0; i < 6; i++)
      begin
         fsrc <= 6'h01 << i;
         tick(6);
         chk("fpin", 8'(fpin), 8'h00);
         chk("drive", 8'({TOP_N_OE, BOTTOM}), 8'(i == 1 ? 6'h08 : 6'h00));
         fsrc <= 6'h00;
         tick(6);
         rd(mfp_pkg::ADR_STATUS, 8'h80 | (8'h01 << (mfp_pkg::EV_ENABLE + i)));
         wr(mfp_pkg::ADR_STATUS, 8'hFF);
         rd(mfp_pkg::ADR_STATUS, 8'h00);
      end
      // invalid code, then brake, then undervoltage over brake
      wr(mfp_pkg::ADR_CTRL, 8'h00);
      SENSOR <= 3'h0;
      tick(6);
      chk("inv", 8'({fpin, TOP_N_OE, BOTTOM}), 8'h00);
      BRAKE <= 1'b1;
      tick(5);
      chk("brk", 8'({fpin, TOP_N_OE, BOTTOM}), 8'h07);
      SENSOR <= 3'h5;
      tick(5);
      chk("brk", 8'({fpin, TOP_N_OE, BOTTOM}), 8'h47);
      fsrc <= 6'h04;
      tick(5);
      chk("uvb", 8'({fpin, TOP_N_OE, BOTTOM}), 8'h00);
      rd(mfp_pkg::ADR_LIVE, 8'h88);
      fsrc <= 6'h00;
      BRAKE <= 1'b0;
      tick(6);
      // interrupt raised, masked and cleared
      wr(mfp_pkg::ADR_STATUS, 8'hFF);
      wr(mfp_pkg::ADR_MASK, 8'h02);
      chk("irq", 8'(IRQ), 8'h00);
      fsrc <= 6'h01;
      tick(4);
      fsrc <= 6'h00;
      tick(5);
      chk("irq", 8'(IRQ), 8'h01);
      wr(mfp_pkg::ADR_MASK, 8'h00);
      chk("irq", 8'(IRQ), 8'h00);
      wr(mfp_pkg::ADR_MASK, 8'h02);
      wr(mfp_pkg::ADR_STATUS, 8'hFF);
      chk("irq", 8'(IRQ), 8'h00);
      // pwm pulse length, then one overcurrent cut per ramp
      wr(mfp_pkg::ADR_DUTY, duty_of(4'h5));
      wb(1'b0);
      wb(1'b1);
      n = 0;
      while ((|BOTTOM) === 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
      chk("duty", 8'(n), 8'h64);
      wb(1'b1);
      tick(10);
      fsrc <= 6'h02;
      tick(2);
      fsrc <= 6'h00;
      n = 0;
      repeat (170)
      begin
         tick(1);
         n += 32'(|BOTTOM);
      end
      chk("oc", 8'(n), 8'h00);
      wb(1'b1);
      // sustained overcurrent trips the far latch until it is cleared
      fsrc <= 6'h02;
      tick(60);
      fsrc <= 6'h00;
      tick(10);
      chk("latch", 8'({latched, fpin}), 8'h02);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(6);
      chk("unlatch", 8'({latched, fpin}), 8'h01);
      summarize();
   end
endmodule : motor_fault_protection_logic_tb_top
